/* File: hdl/osw_pkg.sv */
// Shared constants and types for the OSD serial write port
// Summary of operation
// - Driven select pin selects SPI-style mode
// - Controller holds select low through whole packet
// - Floating select pin selects I2C slave mode
// - I2C transfers open with fixed slave address
// - Packets built from row, column, data bytes
// - Streaming format auto-increments column, wraps row
// - Controller sends filler for unused stream columns
// - Address bit 7 set means row index
// - Bit 7 clear: column; bit 6 picks stream
// - Format a may become b or c, b back to a
// - Stream format keeps data-only until transfer end
// - One source drives memory address at a time
// - Serial writes commit only in scan-timed slots
// - Display scan address increments on its own
// - Serial data sampled on controller serial clock
// - Controller picks format by update size
// - Memory holds rows 0-10 by 32 columns
package osw_pkg;
  // Timing
  localparam int SYS_PERIOD_NS  = 10;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  // Protocol values
  localparam logic [7:0] SLAVE_ADDR   = 8'h7a;
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] ACK_SLOT     = 4'h8;
  localparam int         ROW_FLAG_BIT = 7;
  localparam int         STREAM_BIT   = 6;
  // Display memory map
  localparam int         MEM_DEPTH = 352;
  localparam logic [3:0] ROW_LAST  = 4'ha;
  localparam logic [4:0] COL_LAST  = 5'h1f;
  localparam logic [8:0] SCAN_LAST = 9'h15f;
  // Access slots within the eight-cycle scan period
  localparam logic [2:0] SLOT_SCAN  = 3'h0;
  localparam logic [2:0] SLOT_WRITE = 3'h4;
  // Synchronised pin positions and their reset levels
  localparam int         PIN_SEL  = 0;
  localparam int         PIN_DRV  = 1;
  localparam int         PIN_SDA  = 2;
  localparam int         PIN_SCK  = 3;
  localparam int         PIN_TOG  = 4;
  localparam int         PIN_NUM  = 5;
  localparam logic [4:0] PIN_RST  = 5'h0f;
  // Command buffer shape
  localparam int FIFO_W     = 9;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    FS_ROW    = 3'b000,
    FS_COL    = 3'b001,
    FS_DATA   = 3'b010,
    FS_NEXT   = 3'b011,
    FS_STREAM = 3'b100
  } osw_fmt_e;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_BITS  = 3'b010,
    H_ACK   = 3'b011,
    H_WAIT  = 3'b100,
    H_STOP  = 3'b101
  } osw_host_e;
endpackage

/* File: hdl/osw_link_if.sv */
// Serial link between the controller and the OSD write port
`timescale 1ns/1ps
interface osw_link_if;
  logic sck;
  logic sel_out;
  logic sel_oe;
  logic sda_out;
  logic sda_oe;
  logic sel_in;
  logic sel_driven;
  logic sda_in;

  // Pull-ups hold undriven pins high; floating select is seen via its enable
  assign sda_in     = sda_oe ? sda_out : 1'b1;
  assign sel_in     = sel_oe ? sel_out : 1'b1;
  assign sel_driven = sel_oe;

  modport ctrl (output sck, output sel_out, output sel_oe, output sda_out, output sda_oe, input sda_in);
  modport dev  (input sck, input sel_in, input sel_driven, input sda_in);
endinterface

/* File: hdl/osw_dev.sv */
// Device end: serial receiver, format decoder and display memory arbiter
`timescale 1ns/1ps
module osw_dev (
  // System (dot) clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // Serial link
  osw_link_if.dev         link,
  // Display scan read port
  output logic      [8:0] scan_addr_out,
  output logic      [7:0] scan_data_out,
  output logic            scan_valid_out,
  // Status
  output logic            i2c_mode_out,
  output logic            frame_active_out,
  output logic            overrun_out
);
  typedef struct packed {
    logic [osw_pkg::PIN_NUM-1:0][2:0] sync;
    logic [osw_pkg::PIN_NUM-1:0]      filt;
    logic                             in_frame;
    logic                             first;
    logic                             addr_ok;
    logic [3:0]                       bitn;
    logic [7:0]                       shreg;
    osw_pkg::osw_fmt_e                fmt;
    logic [3:0]                       row;
    logic [4:0]                       col;
    logic                             pend;
    logic [8:0]                       wr_addr;
    logic [7:0]                       wr_data;
    logic [2:0]                       phase;
    logic [8:0]                       scan;
    logic [8:0]                       scan_addr;
    logic                             scan_valid;
    logic                             overrun;
  } osw_dev_s;

  osw_dev_s q;
  osw_dev_s d;

  // Link-clock side: reset synchroniser, sampled bit and bit toggle
  logic [1:0] lk_rst_q;
  logic       bit_lk_q;
  logic       tog_lk_q;

  // Display memory and its single address port
  logic [7:0] mem [osw_pkg::MEM_DEPTH];
  logic [7:0] rd_q;
  logic [8:0] mem_addr;
  logic       mem_we;

  logic [osw_pkg::PIN_NUM-1:0] pins;
  logic [osw_pkg::PIN_NUM-1:0] chg;
  logic [osw_pkg::PIN_NUM-1:0] lvl;
  logic                        i2c;
  logic                        start_ev;
  logic                        end_ev;
  logic [7:0]                  byte_v;
  logic                        byte_ev;
  logic                        wr_ev;
  logic [7:0]                  wr_byte;

  // Sample the data pin on the controller's rising clock edge
  always_ff @(posedge link.sck) begin
    lk_rst_q <= {lk_rst_q[0], rst_in};
    if (lk_rst_q[1]) begin
      tog_lk_q <= 1'b0;
      bit_lk_q <= 1'b1;
    end else begin
      bit_lk_q <= link.sda_in;
      tog_lk_q <= ~tog_lk_q;
    end
  end

  assign pins = {tog_lk_q, link.sck, link.sda_in, link.sel_driven, link.sel_in};

  // Next-state logic for the system-clock side
  always_comb begin
    d       = q;
    byte_v  = 8'h00;
    byte_ev = 1'b0;
    wr_ev   = 1'b0;
    wr_byte = 8'h00;
    chg     = '0;
    lvl     = '0;
    // Three-stage synchronisers; a change counts when stages two and three agree
    for (int i = 0; i < osw_pkg::PIN_NUM; i++) begin
      d.sync[i] = {q.sync[i][1:0], pins[i]};
      lvl[i]    = q.sync[i][2];
      chg[i]    = (q.sync[i][2] == q.sync[i][1]) && (q.sync[i][2] != q.filt[i]);
      if (q.sync[i][2] == q.sync[i][1]) begin
        d.filt[i] = q.sync[i][2];
      end
    end
    // A driven select pin means SPI-style, a floating one means I2C
    i2c = ~q.filt[osw_pkg::PIN_DRV];
    if (i2c) begin
      start_ev = chg[osw_pkg::PIN_SDA] && !lvl[osw_pkg::PIN_SDA] && q.filt[osw_pkg::PIN_SCK];
      end_ev   = chg[osw_pkg::PIN_SDA] && lvl[osw_pkg::PIN_SDA] && q.filt[osw_pkg::PIN_SCK];
    end else begin
      start_ev = chg[osw_pkg::PIN_SEL] && !lvl[osw_pkg::PIN_SEL];
      end_ev   = chg[osw_pkg::PIN_SEL] && lvl[osw_pkg::PIN_SEL];
    end

    // Framing: every transfer starts expecting a row address
    if (start_ev) begin
      d.in_frame = 1'b1;
      d.first    = i2c;
      d.addr_ok  = ~i2c;
      d.bitn     = 4'h0;
      d.fmt      = osw_pkg::FS_ROW;
    end else if (end_ev) begin
      d.in_frame = 1'b0;
    end

    // Bits arrive through the toggle crossing; the held bit is stable by then
    if (chg[osw_pkg::PIN_TOG] && q.in_frame && !start_ev) begin
      if (q.bitn == osw_pkg::ACK_SLOT) begin
        d.bitn = 4'h0; // I2C acknowledge slot carries nothing
      end else begin
        d.shreg = {q.shreg[6:0], bit_lk_q};
        d.bitn  = q.bitn + 4'h1;
        if (q.bitn == osw_pkg::BIT_LAST) begin
          byte_v  = {q.shreg[6:0], bit_lk_q};
          byte_ev = 1'b1;
          d.bitn  = i2c ? osw_pkg::ACK_SLOT : 4'h0;
        end
      end
    end

    // Slave address gate in I2C mode
    if (byte_ev && q.first) begin
      d.first   = 1'b0;
      d.addr_ok = (byte_v == osw_pkg::SLAVE_ADDR);
    end else if (byte_ev && q.addr_ok) begin
      // Format machine
      unique case (q.fmt)
        osw_pkg::FS_ROW: begin
          if (byte_v[osw_pkg::ROW_FLAG_BIT]) begin
            d.row = byte_v[3:0];
            d.fmt = osw_pkg::FS_COL;
          end
        end
        osw_pkg::FS_COL: begin
          if (!byte_v[osw_pkg::ROW_FLAG_BIT]) begin
            d.col = byte_v[4:0];
            d.fmt = byte_v[osw_pkg::STREAM_BIT] ? osw_pkg::FS_STREAM : osw_pkg::FS_DATA;
          end
        end
        osw_pkg::FS_DATA: begin
          wr_ev   = 1'b1;
          wr_byte = byte_v;
          d.fmt   = osw_pkg::FS_NEXT;
        end
        osw_pkg::FS_NEXT: begin
          if (byte_v[osw_pkg::ROW_FLAG_BIT]) begin
            d.row = byte_v[3:0];
            d.fmt = osw_pkg::FS_COL;
          end else begin
            d.col = byte_v[4:0];
            d.fmt = byte_v[osw_pkg::STREAM_BIT] ? osw_pkg::FS_STREAM : osw_pkg::FS_DATA;
          end
        end
        osw_pkg::FS_STREAM: begin
          // Stays here until the frame ends; every byte is data
          wr_ev   = 1'b1;
          wr_byte = byte_v;
          d.col   = q.col + 5'h01;
          if (q.col == osw_pkg::COL_LAST) begin
            d.row = q.row + 4'h1;
          end
        end
        default: begin
          d.fmt = osw_pkg::FS_ROW;
        end
      endcase
    end

    // Slot timing: the scan reads in one slot, serial writes land in another
    d.phase      = q.phase + 3'h1;
    d.scan_valid = (q.phase == osw_pkg::SLOT_SCAN);
    if (q.phase == osw_pkg::SLOT_SCAN) begin
      d.scan_addr = q.scan;
      d.scan      = (q.scan == osw_pkg::SCAN_LAST) ? 9'h000 : q.scan + 9'h001;
    end
    if (mem_we) begin
      d.pend = 1'b0;
    end
    // New write after the drain, so a write landing on the drain cycle survives
    d.overrun = 1'b0;
    if (wr_ev && q.row <= osw_pkg::ROW_LAST) begin
      if (d.pend) begin
        d.overrun = 1'b1;
      end else begin
        d.pend    = 1'b1;
        d.wr_addr = {q.row, q.col};
        d.wr_data = wr_byte;
      end
    end
  end

  // Only the write slot hands the address port to the serial side
  assign mem_we   = q.pend && (q.phase == osw_pkg::SLOT_WRITE);
  assign mem_addr = mem_we ? q.wr_addr : q.scan;

  // Display memory; one access per cycle keeps it a single-port array
  always_ff @(posedge sys_clk_in) begin
    if (mem_we) begin
      mem[mem_addr] <= q.wr_data;
    end
    rd_q <= mem[mem_addr];
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q          <= '0;
      q.filt     <= osw_pkg::PIN_RST;
      // Synchronisers start at each pin's idle level, so reset leaves no false edge
      for (int i = 0; i < osw_pkg::PIN_NUM; i++) begin
        q.sync[i] <= {3{osw_pkg::PIN_RST[i]}};
      end
      q.fmt      <= osw_pkg::FS_ROW;
    end else begin
      q <= d;
    end
  end

  assign scan_addr_out    = q.scan_addr;
  assign scan_data_out    = rd_q;
  assign scan_valid_out   = q.scan_valid;
  assign i2c_mode_out     = ~q.filt[osw_pkg::PIN_DRV];
  assign frame_active_out = q.in_frame;
  assign overrun_out      = q.overrun;
endmodule

/* File: hdl/osw_host.sv */
// Controller end: command FIFO and SPI-style / I2C serial transmitter
`timescale 1ns/1ps
module osw_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Fill side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // Drain side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic      [W-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;

  // Extra pointer bit tells full from empty
  assign in_ready_out  = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid_out = (wp_q != rp_q);
  assign out_data_out  = mem[rp_q[AW-1:0]];

  always_ff @(posedge clk_in) begin
    if (in_valid_in && in_ready_out) begin
      mem[wp_q[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (in_valid_in && in_ready_out) begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_valid_out && out_ready_in) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule

module osw_host (
  // System clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // Command stream: one byte per beat, last closes the transfer
  input  wire logic       cmd_valid_in,
  output logic            cmd_ready_out,
  input  wire logic [7:0] cmd_data_in,
  input  wire logic       cmd_last_in,
  // Mode and status
  input  wire logic       mode_i2c_in,
  output logic            busy_out,
  // Serial link
  osw_link_if.ctrl        link
);
  typedef struct packed {
    osw_pkg::osw_host_e st;
    logic [3:0]         tmr;
    logic [3:0]         bitn;
    logic [7:0]         sh;
    logic               last;
    logic               i2c;
    logic               addr_ph;
    logic               sck;
    logic               sda;
    logic               sda_oe;
    logic               sel;
    logic               sel_oe;
  } osw_host_s;

  localparam logic [3:0] HALF_LAST = 4'(osw_pkg::LINK_HALF_CYC - 1);
  localparam logic [3:0] HALF_MID  = 4'(osw_pkg::LINK_HALF_CYC / 2 - 1);

  osw_host_s  q;
  osw_host_s  d;
  logic       f_valid;
  logic       take;
  logic [8:0] f_data;
  logic       mid;

  // User bytes, filler and format choice included, pass through unchanged
  osw_fifo #(.W(osw_pkg::FIFO_W), .DEPTH(osw_pkg::FIFO_DEPTH)) u_fifo (
    .clk_in        (sys_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (cmd_valid_in),
    .in_ready_out  (cmd_ready_out),
    .in_data_in    ({cmd_last_in, cmd_data_in}),
    .out_valid_out (f_valid),
    .out_ready_in  (take),
    .out_data_out  (f_data)
  );

  // Divider and transfer sequencer; data and select rise move mid-low, select fall and I2C start/stop mid-high
  always_comb begin
    d    = q;
    take = 1'b0;
    mid  = (q.tmr == HALF_MID);
    // Clock stalls low while waiting for the next byte inside a transfer
    if (q.st != osw_pkg::H_WAIT || f_valid) begin
      d.tmr = (q.tmr == HALF_LAST) ? 4'h0 : q.tmr + 4'h1;
      if (q.tmr == HALF_LAST) begin
        d.sck = ~q.sck;
      end
    end
    unique case (q.st)
      osw_pkg::H_IDLE: begin
        d.i2c     = mode_i2c_in;
        d.sel_oe  = ~mode_i2c_in;
        d.sel     = 1'b1;
        d.sda_oe  = ~mode_i2c_in;
        d.sda     = 1'b1;
        d.addr_ph = mode_i2c_in;
        // Select falls in the high phase, so no clock rise comes before the first data bit
        if (f_valid && mid && q.sck && !q.i2c) begin
          d.sel = 1'b0;
          d.st  = osw_pkg::H_SETUP;
        end else if (f_valid && mid && q.sck && q.i2c) begin
          d.sda_oe = 1'b1;
          d.sda    = 1'b0;
          d.st     = osw_pkg::H_SETUP;
        end
      end
      osw_pkg::H_SETUP, osw_pkg::H_WAIT: begin
        // Between bytes, load at once: a clock rise with no data bit would slip the receiver
        if (!q.sck && (mid || q.st == osw_pkg::H_WAIT) && (q.addr_ph || f_valid)) begin
          take     = !q.addr_ph;
          d.sh     = q.addr_ph ? osw_pkg::SLAVE_ADDR : f_data[7:0];
          d.last   = q.addr_ph ? 1'b0 : f_data[8];
          d.sda    = q.addr_ph ? osw_pkg::SLAVE_ADDR[7] : f_data[7];
          d.sda_oe = 1'b1;
          d.bitn   = 4'h0;
          d.st     = osw_pkg::H_BITS;
        end
      end
      osw_pkg::H_BITS: begin
        if (mid && !q.sck) begin
          if (q.bitn == osw_pkg::BIT_LAST) begin
            if (q.i2c) begin
              d.sda_oe = 1'b0;
              d.st     = osw_pkg::H_ACK;
            end else if (q.last) begin
              d.sel = 1'b1;
              d.st  = osw_pkg::H_IDLE;
            end else begin
              d.st = osw_pkg::H_WAIT;
            end
          end else begin
            d.bitn = q.bitn + 4'h1;
            d.sh   = {q.sh[6:0], 1'b0};
            d.sda  = q.sh[6];
          end
        end
      end
      osw_pkg::H_ACK: begin
        if (mid && !q.sck) begin
          d.addr_ph = 1'b0;
          if (q.last) begin
            d.sda_oe = 1'b1;
            d.sda    = 1'b0;
            d.st     = osw_pkg::H_STOP;
          end else begin
            d.st = osw_pkg::H_WAIT;
          end
        end
      end
      osw_pkg::H_STOP: begin
        if (mid && q.sck) begin
          d.sda_oe = 1'b0; // Released data rises while clock high
          d.st     = osw_pkg::H_IDLE;
        end
      end
      default: begin
        d.st = osw_pkg::H_IDLE;
      end
    endcase
    // Stalled wait must leave the data line alone
    if (q.st == osw_pkg::H_WAIT && !f_valid) begin
      d.sda = q.sda;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q        <= '0;
      q.st     <= osw_pkg::H_IDLE;
      q.sck    <= 1'b1;
      q.sda    <= 1'b1;
      q.sel    <= 1'b1;
      q.sel_oe <= 1'b1;
      q.sda_oe <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.sck     = q.sck;
  assign link.sel_out = q.sel;
  assign link.sel_oe  = q.sel_oe;
  assign link.sda_out = q.sda;
  assign link.sda_oe  = q.sda_oe;
  assign busy_out     = (q.st != osw_pkg::H_IDLE) || f_valid;
endmodule

/* File: tb/osw_link_props.sv */
// Link wire and scan timing checks for the serial write port
`timescale 1ns/1ps
module osw_link_props (
  // Clock and reset
  input wire logic       sys_clk_in,
  input wire logic       rst_in,
  // Link wires
  input wire logic       sck,
  input wire logic       sel_in,
  input wire logic       sel_driven,
  input wire logic       sda_in,
  // Device outputs
  input wire logic [8:0] scan_addr_out,
  input wire logic       scan_valid_out,
  input wire logic       i2c_mode_out,
  input wire logic       overrun_out
);
  logic       sck_q;
  logic       sda_q;
  logic [3:0] bits_q;
  logic [7:0] addr_q;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // Collect the first byte after an I2C start; 9 means no address in flight
  always_ff @(posedge sys_clk_in) begin
    sck_q <= sck;
    sda_q <= sda_in;
    if (rst_in) begin
      bits_q <= 4'h9;
      addr_q <= 8'h00;
    end else if (!sel_driven && sck && sck_q && sda_q && !sda_in) begin
      bits_q <= 4'h0;
    end else if (!sel_driven && sck && !sck_q && bits_q < 4'h9) begin
      bits_q <= bits_q + 4'h1;
      addr_q <= {addr_q[6:0], sda_in};
    end
  end

  // Mode follows the select pin once the synchroniser has settled
  spi_mode_a: assert property (sel_driven [*8] |-> !i2c_mode_out)
    else $error("driven select did not give SPI mode");
  i2c_mode_a: assert property ((!sel_driven) [*8] |-> i2c_mode_out)
    else $error("floating select did not give I2C mode");
  // Select may not rise right behind a sampling edge
  sel_hold_a: assert property (sel_driven && !sel_in && $rose(sck) |-> !sel_in [*8])
    else $error("select released too close to a clock rise");
  spi_data_a: assert property (sel_driven && !sel_in && $rose(sck) |-> $stable(sda_in) ##1 $stable(sda_in))
    else $error("data moved around a clock rise");
  slave_addr_a: assert property ($rose(bits_q == 4'h8) |-> addr_q == osw_pkg::SLAVE_ADDR)
    else $error("wrong I2C slave address sent");
  // Scan owns one slot in eight, stepping the address by one
  scan_pace_a: assert property (scan_valid_out |=> !scan_valid_out [*7] ##1 scan_valid_out)
    else $error("scan slot spacing broken");
  scan_step_a: assert property (scan_valid_out ##8 scan_valid_out |-> scan_addr_out ==
      (($past(scan_addr_out, 8) == osw_pkg::SCAN_LAST) ? 9'h000 : $past(scan_addr_out, 8) + 9'h001))
    else $error("scan address did not step");
  // Host paces bytes far slower than the write slots, so nothing may drop
  no_overrun_a: assert property (!overrun_out)
    else $error("serial write dropped");

  spi_end_c: cover property (sel_driven && $rose(sel_in));
  i2c_addr_c: cover property ($rose(bits_q == 4'h8));
  scan_wrap_c: cover property (scan_valid_out && scan_addr_out == osw_pkg::SCAN_LAST);
endmodule

/* File: tb/osd_serial_write_port_test.sv */
// Self-checking bench: host end writes display memory through the device end
`timescale 1ns/1ps
module osd_serial_write_port_test;
  logic       sys_clk;
  logic       rst_host;
  logic       rst_dev;
  logic       cmd_valid;
  logic       cmd_ready;
  logic [7:0] cmd_data;
  logic       cmd_last;
  logic       mode_i2c;
  logic       busy;
  logic [8:0] scan_addr;
  logic [7:0] scan_data;
  logic       scan_valid;
  logic       i2c_mode;
  logic       frame_active;
  logic       overrun;
  logic       saw_full;
  int         n_errors;
  int         checks_done;
  integer     seed;
  logic [8:0] exp_a[$];
  logic [7:0] exp_d[$];
  logic [7:0] bytes[$];

  osw_link_if osw_link_if_i ();
  osw_host osw_host_i (.sys_clk_in(sys_clk), .rst_in(rst_host), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_data_in(cmd_data), .cmd_last_in(cmd_last),
    .mode_i2c_in(mode_i2c), .busy_out(busy), .link(osw_link_if_i.ctrl));
  osw_dev osw_dev_i (.sys_clk_in(sys_clk), .rst_in(rst_dev), .link(osw_link_if_i.dev),
    .scan_addr_out(scan_addr), .scan_data_out(scan_data), .scan_valid_out(scan_valid),
    .i2c_mode_out(i2c_mode), .frame_active_out(frame_active), .overrun_out(overrun));
  osw_link_props osw_link_props_i (.sys_clk_in(sys_clk), .rst_in(rst_dev), .sck(osw_link_if_i.sck),
    .sel_in(osw_link_if_i.sel_in), .sel_driven(osw_link_if_i.sel_driven), .sda_in(osw_link_if_i.sda_in),
    .scan_addr_out(scan_addr), .scan_valid_out(scan_valid), .i2c_mode_out(i2c_mode),
    .overrun_out(overrun));

  // 100 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t memory byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic compare_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic timeout();
    n_errors++;
    $display("MISMATCH t=%0t wait limit ran out", $time);
    give_verdict();
  endtask

  // Offer a byte at a falling edge; ready only changes at rising edges, so it is read here
  task automatic push(input logic [7:0] b, input logic last);
    int k;
    cmd_valid = 1'b1;
    cmd_data  = b;
    cmd_last  = last;
    for (k = 0; k < 2000 && cmd_ready !== 1'b1; k++) begin
      saw_full = 1'b1;
      @(negedge sys_clk);
    end
    if (k == 2000) timeout();
    @(negedge sys_clk);
  endtask

  // Send all queued bytes as one transfer and give the last write time to land
  task automatic xfer();
    int k;
    foreach (bytes[i]) push(bytes[i], i == bytes.size() - 1);
    cmd_valid = 1'b0;
    for (k = 0; k < 20000 && busy !== 1'b0; k++) @(negedge sys_clk);
    if (k == 20000) timeout();
    repeat (64) @(negedge sys_clk);
    compare_flag(frame_active, 1'b0);
  endtask

  task automatic note(input logic [8:0] a, input logic [7:0] d);
    exp_a.push_back(a);
    exp_d.push_back(d);
  endtask

  // Notes go in ascending address order, so two scan passes always suffice
  task automatic drain();
    int k;
    for (k = 0; k < 8000 && exp_a.size() != 0; k++) @(negedge sys_clk);
    if (k == 8000) timeout();
  endtask

  // Scan watcher: the oldest note is checked when the scan reads its address; sampled mid-cycle
  always @(negedge sys_clk) begin
    if (scan_valid === 1'b1 && exp_a.size() != 0 && scan_addr === exp_a[0]) begin
      compare_byte(scan_data, exp_d[0]);
      void'(exp_a.pop_front());
      void'(exp_d.pop_front());
    end
  end

  initial begin
    logic [7:0] d[0:11];
    int k;
    seed = 32'h8173;
    n_errors = 0;
    checks_done = 0;
    saw_full = 1'b0;
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    cmd_last = 1'b0;
    mode_i2c = 1'b0;
    rst_host = 1'b1;
    rst_dev = 1'b1;
    for (k = 0; k < 12; k++) d[k] = 8'($random(seed));
    repeat (8) @(negedge sys_clk);
    // Host leaves reset first so link clock edges reach the device before it does
    rst_host = 1'b0;
    repeat (48) @(negedge sys_clk);
    rst_dev = 1'b0;
    // Link-side reset needs two serial clock rises to clear before the first frame
    repeat (64) @(negedge sys_clk);
    compare_flag(i2c_mode, 1'b0);
    bytes = {8'h82, 8'h03, d[0], 8'h85, 8'h07, d[1]};
    xfer();
    note({4'h2, 5'h03}, d[0]);
    note({4'h5, 5'h07}, d[1]);
    drain();
    bytes = {8'h81, 8'h00, d[2], 8'h17, d[3], 8'h83, 8'h04, d[4]};
    xfer();
    note({4'h1, 5'h00}, d[2]);
    note({4'h1, 5'h17}, d[3]);
    note({4'h3, 5'h04}, d[4]);
    drain();
    // Stream entered from format a, wraps into the next row, and swallows a row byte as data
    bytes = {8'h84, 8'h01, d[5], 8'h5e, d[6], d[7], d[8], 8'h86};
    xfer();
    note({4'h4, 5'h01}, d[5]);
    note({4'h4, 5'h1e}, d[6]);
    note({4'h4, 5'h1f}, d[7]);
    note({4'h5, 5'h00}, d[8]);
    note({4'h5, 5'h01}, 8'h86);
    drain();
    bytes = {8'hf6, 8'h22, d[9]};
    xfer();
    note({4'h6, 5'h02}, d[9]);
    drain();
    mode_i2c = 1'b1;
    for (k = 0; k < 200 && i2c_mode !== 1'b1; k++) @(negedge sys_clk);
    compare_flag(i2c_mode, 1'b1);
    bytes = {8'h8a, 8'h0c, d[10], 8'h87, 8'h09, d[11]};
    xfer();
    note({4'h7, 5'h09}, d[11]);
    note({4'ha, 5'h0c}, d[10]);
    drain();
    // Long stream overfills the command buffer and crosses the filler columns
    bytes = {8'h80, 8'h40};
    for (k = 0; k < 38; k++) bytes.push_back(8'($random(seed)));
    xfer();
    for (k = 0; k < 38; k++) note(9'(k), bytes[k + 2]);
    compare_flag(saw_full, 1'b1);
    compare_flag(cmd_ready, 1'b1);
    drain();
    give_verdict();
  end
endmodule
